/* logic/srab_bridge.sv */
// Host command bridge: UART receive, byte FIFO, command engine, SPI master, UART send
`timescale 1ns/10ps
`include "srab_consts.svh"

module srab_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    always_comb begin
        in_ready = (wp_q - rp_q) != (AW+1)'(D);
        out_valid = wp_q != rp_q;
        out_data = mem_q[rp_q[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule

module srab_bridge import srab_pkg::*; #(
    parameter logic [13:0] BAUD_DIV = 14'(`SRAB_BAUD_CYC)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Host serial link
    input wire logic uart_rx,
    output logic uart_tx_q,
    // Converter port
    output srab_spi_t spi_q,
    input wire logic spi_miso,
    // Status
    output logic busy_q,
    output logic overrun_q
);
    function automatic logic is_cmd(input logic [7:0] b);
        case (b)
            `SRAB_WR_OFFSET, `SRAB_WR_GAIN, `SRAB_WR_CONFIG,
            `SRAB_RD_OFFSET, `SRAB_RD_GAIN, `SRAB_RD_CONFIG, `SRAB_RD_RESULT: is_cmd = 1'b1;
            default: is_cmd = 1'b0;
        endcase
    endfunction

    // Pin synchronisers
    logic rx_m_q, rx_s_q, mi_m_q, mi_s_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {rx_m_q, rx_s_q, mi_m_q, mi_s_q} <= 4'hf;
        end else begin
            rx_m_q <= uart_rx;
            rx_s_q <= rx_m_q;
            mi_m_q <= spi_miso;
            mi_s_q <= mi_m_q;
        end
    end

    // UART receiver, 8N1, LSB first
    logic rx_busy_q, rx_busy_d, rx_push;
    logic [13:0] rx_cnt_q, rx_cnt_d;
    logic [3:0] rx_n_q, rx_n_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic f_ready, f_valid, f_pop, ovr_d;
    logic [7:0] f_data;

    always_comb begin
        rx_busy_d = rx_busy_q;
        rx_cnt_d = rx_cnt_q;
        rx_n_d = rx_n_q;
        rx_sh_d = rx_sh_q;
        rx_push = 1'b0;
        if (!rx_busy_q) begin
            if (!rx_s_q) begin
                rx_busy_d = 1'b1;
                rx_cnt_d = BAUD_DIV >> 1;
                rx_n_d = 4'h0;
            end
        end else if (rx_cnt_q != 14'h0) begin
            rx_cnt_d = rx_cnt_q - 14'h1;
        end else begin
            rx_cnt_d = BAUD_DIV - 14'h1;
            rx_n_d = rx_n_q + 4'h1;
            if (rx_n_q == 4'h0 && rx_s_q) begin
                rx_busy_d = 1'b0; // Glitch, not a start bit
            end else if (rx_n_q == 4'h9) begin
                rx_busy_d = 1'b0;
                rx_push = rx_s_q; // Bad stop bit drops the byte
            end else if (rx_n_q != 4'h0) begin
                rx_sh_d = {rx_s_q, rx_sh_q[7:1]};
            end
        end
        // Host cannot be paused, so a full FIFO loses the byte and flags it
        ovr_d = overrun_q || (rx_push && !f_ready);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q <= 14'h0;
            rx_n_q <= 4'h0;
            rx_sh_q <= 8'h0;
            overrun_q <= 1'b0;
        end else begin
            rx_busy_q <= rx_busy_d;
            rx_cnt_q <= rx_cnt_d;
            rx_n_q <= rx_n_d;
            rx_sh_q <= rx_sh_d;
            overrun_q <= ovr_d;
        end
    end

    srab_fifo #(.W(8), .D(`SRAB_FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_data(rx_sh_q),
        .in_valid(rx_push),
        .in_ready(f_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );

    // Command engine, SPI master and UART sender
    srab_state_t st_q, st_d;
    logic [1:0] bc_q, bc_d;
    logic [7:0] cmd_q, cmd_d;
    logic [23:0] data_q, data_d, in_q, in_d;
    logic [31:0] sh_q, sh_d;
    logic [3:0] hc_q, hc_d;
    logic [6:0] ec_q, ec_d;
    srab_spi_t spi_d;
    logic tx_busy_q, tx_busy_d, tx_q_d, tx_load;
    logic [13:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] tx_n_q, tx_n_d;
    logic [8:0] tx_sh_q, tx_sh_d;

    always_comb begin
        st_d = st_q;
        bc_d = bc_q;
        cmd_d = cmd_q;
        data_d = data_q;
        in_d = in_q;
        sh_d = sh_q;
        hc_d = hc_q;
        ec_d = ec_q;
        spi_d = spi_q;
        f_pop = (st_q == ST_IDLE || st_q == ST_GETD) && f_valid;
        tx_load = 1'b0;
        tx_busy_d = tx_busy_q;
        tx_cnt_d = tx_cnt_q;
        tx_n_d = tx_n_q;
        tx_sh_d = tx_sh_q;
        tx_q_d = uart_tx_q;
        case (st_q)
            ST_IDLE: begin
                if (f_pop && is_cmd(f_data)) begin
                    cmd_d = f_data;
                    bc_d = 2'h0;
                    data_d = 24'h0;
                    st_d = f_data[4] ? ST_SPI : ST_GETD;
                end
            end
            ST_GETD: begin
                if (f_pop) begin
                    data_d = {f_data, data_q[23:8]};
                    bc_d = bc_q + 2'h1;
                    if (bc_q == 2'h2) begin
                        st_d = ST_SPI;
                    end
                end
            end
            ST_SPI: begin
                if (ec_q == 7'h0 && hc_q == 4'h0 && spi_q.cs_n) begin
                    spi_d.cs_n = 1'b0;
                    sh_d = {cmd_q, cmd_q[4] ? 24'h0 : data_q};
                    spi_d.mosi = cmd_q[7];
                    hc_d = 4'h1;
                end else if (hc_q != `SRAB_SPI_HALF - 4'h1) begin
                    hc_d = hc_q + 4'h1;
                end else begin
                    hc_d = 4'h0;
                    ec_d = ec_q + 7'h1;
                    if (ec_q < `SRAB_SPI_EDGES - 7'h1) begin
                        spi_d.sclk = !spi_q.sclk;
                        if (!spi_q.sclk) begin
                            in_d = {in_q[22:0], mi_s_q};
                        end else begin
                            sh_d = {sh_q[30:0], 1'b0};
                            spi_d.mosi = sh_q[30];
                        end
                    end else begin
                        spi_d.cs_n = 1'b1;
                        spi_d.mosi = 1'b0;
                        ec_d = 7'h0;
                        bc_d = 2'h0;
                        if (cmd_q[4]) begin
                            data_d = in_q;
                            st_d = ST_SEND;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
            end
            ST_SEND: begin
                if (!tx_busy_q) begin
                    if (bc_q == 2'h3) begin
                        st_d = ST_IDLE;
                    end else begin
                        tx_load = 1'b1;
                        bc_d = bc_q + 2'h1;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (tx_load) begin
            tx_busy_d = 1'b1;
            tx_q_d = 1'b0;
            tx_sh_d = {1'b1, data_q[8*bc_q +: 8]};
            tx_n_d = 4'h9;
            tx_cnt_d = BAUD_DIV - 14'h1;
        end else if (tx_busy_q) begin
            if (tx_cnt_q != 14'h0) begin
                tx_cnt_d = tx_cnt_q - 14'h1;
            end else if (tx_n_q != 4'h0) begin
                tx_q_d = tx_sh_q[0];
                tx_sh_d = {1'b1, tx_sh_q[8:1]};
                tx_n_d = tx_n_q - 4'h1;
                tx_cnt_d = BAUD_DIV - 14'h1;
            end else begin
                tx_busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            bc_q <= 2'h0;
            cmd_q <= 8'h0;
            data_q <= 24'h0;
            in_q <= 24'h0;
            sh_q <= 32'h0;
            hc_q <= 4'h0;
            ec_q <= 7'h0;
            spi_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
            tx_busy_q <= 1'b0;
            tx_cnt_q <= 14'h0;
            tx_n_q <= 4'h0;
            tx_sh_q <= 9'h1ff;
            uart_tx_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bc_q <= bc_d;
            cmd_q <= cmd_d;
            data_q <= data_d;
            in_q <= in_d;
            sh_q <= sh_d;
            hc_q <= hc_d;
            ec_q <= ec_d;
            spi_q <= spi_d;
            tx_busy_q <= tx_busy_d;
            tx_cnt_q <= tx_cnt_d;
            tx_n_q <= tx_n_d;
            tx_sh_q <= tx_sh_d;
            uart_tx_q <= tx_q_d;
            busy_q <= st_d != ST_IDLE;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_tx_start;
        $rose(tx_busy_q) |-> !uart_tx_q ##1 !uart_tx_q;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit missing");
    property p_wr_code;
        st_q == ST_GETD |-> is_cmd(cmd_q) && !cmd_q[4];
    endproperty
    a_wr_code: assert property (p_wr_code) else $error("bad write code");
    property p_rd_code;
        st_q == ST_SEND |-> is_cmd(cmd_q) && cmd_q[4];
    endproperty
    a_rd_code: assert property (p_rd_code) else $error("bad read code");
    property p_wr_word;
        $fell(spi_q.cs_n) && !cmd_q[4] |-> sh_q == {cmd_q, data_q};
    endproperty
    a_wr_word: assert property (p_wr_word) else $error("write word wrong");
    property p_rd_low_first;
        tx_load && bc_q == 2'h0 |=> tx_sh_q[7:0] == $past(data_q[7:0]);
    endproperty
    a_rd_low_first: assert property (p_rd_low_first) else $error("low byte not first");
    property p_idle_pins;
        spi_q.cs_n |-> !spi_q.sclk;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("clock high while deselected");
    property p_cs_low_clk;
        $changed(spi_q.cs_n) |-> !spi_q.sclk && !$past(spi_q.sclk);
    endproperty
    a_cs_low_clk: assert property (p_cs_low_clk) else $error("select moved with clock high");
    property p_ignore_sdo;
        spi_q.cs_n |=> $stable(in_q);
    endproperty
    a_ignore_sdo: assert property (p_ignore_sdo) else $error("data taken while deselected");
    property p_drop_bad;
        st_q == ST_IDLE && f_pop && !is_cmd(f_data) |=> st_q == ST_IDLE;
    endproperty
    a_drop_bad: assert property (p_drop_bad) else $error("unknown byte accepted");
    c_write: cover property (st_q == ST_SPI && !cmd_q[4] ##1 st_q == ST_IDLE);
    c_read: cover property (st_q == ST_SEND && bc_q == 2'h3 && !tx_busy_q);
    c_overrun: cover property ($rose(overrun_q));
endmodule

/* logic/srab_consts.svh */
// Constants for the serial register access bridge
// Notes on behaviour
// - The host link runs at 9600 baud with eight data bits, no parity and one stop bit.
// - Write codes 0x80, 0x82 and 0x84 pick offset, gain and configuration.
// - Read codes 0x90, 0x92, 0x94 and 0x96 pick offset, gain, configuration and result.
// - A write code is followed by three data bytes, low byte first, written as one word.
// - A read code makes the bridge fetch the register and return three bytes low first.
// - The converter is driven over chip select, serial clock, data in and data out.
// - While chip select is high the converter data output is ignored.
`ifndef SRAB_CONSTS_SVH
`define SRAB_CONSTS_SVH
`define SRAB_CLK_HZ 125000000
`define SRAB_BAUD 9600
`define SRAB_BAUD_CYC ((`SRAB_CLK_HZ + `SRAB_BAUD / 2) / `SRAB_BAUD)
`define SRAB_WR_OFFSET 8'h80
`define SRAB_WR_GAIN 8'h82
`define SRAB_WR_CONFIG 8'h84
`define SRAB_RD_OFFSET 8'h90
`define SRAB_RD_GAIN 8'h92
`define SRAB_RD_CONFIG 8'h94
`define SRAB_RD_RESULT 8'h96
`define SRAB_SPI_HALF 4'h8
`define SRAB_SPI_EDGES 7'h41
`define SRAB_FIFO_DEPTH 16
`endif

/* logic/srab_pkg.sv */
// Types shared by the serial register access bridge
package srab_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_GETD, ST_SPI, ST_SEND} srab_state_t;
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } srab_spi_t;
endpackage

/* verif/srab_conv_model.sv */
// Behavioural model of the converter register file behind its serial port
`timescale 1ns/10ps
module srab_conv_model (
    // Converter port
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Bench view
    input wire logic [23:0] result_val,
    output logic [7:0] last_cmd
);
    logic [23:0] regs [3] = '{24'h0, 24'h0, 24'h0};
    logic [31:0] shift_q = 32'h0;
    logic [23:0] out_q = 24'h0;
    logic bit_q = 1'b0;
    int cnt = 0;

    // Released line shows the inverse of the last bit, never a stale copy
    assign miso = cs_n ? ~bit_q : bit_q;

    always @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            if (cnt == 32 && shift_q[31:28] == 4'h8) begin
                regs[shift_q[26:25]] <= shift_q[23:0];
            end
            cnt <= 0;
        end else begin
            shift_q <= {shift_q[30:0], mosi};
            cnt <= cnt + 1;
            if (cnt == 7) begin
                last_cmd <= {shift_q[6:0], mosi};
                out_q <= (shift_q[1:0] == 2'h3) ? result_val : regs[shift_q[1:0]];
            end
        end
    end

    // Data moves on the falling clock so it is stable at the rising one
    always @(negedge sclk) begin
        if (!cs_n && cnt >= 8) begin
            bit_q <= out_q[23];
            out_q <= {out_q[22:0], 1'b0};
        end
    end
endmodule

/* verif/srab_bridge_tb.sv */
// Self-checking bench for the serial register access bridge
`timescale 1ns/10ps
module srab_bridge_tb import srab_pkg::*;;
    localparam int BIT = 16;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic uart_rx = 1'b1;
    logic uart_tx_q, spi_miso, busy_q, overrun_q;
    srab_spi_t spi_q;
    logic [23:0] result_val = 24'h0;
    logic [7:0] last_cmd;
    logic [23:0] exp_reg [3];
    logic [7:0] wcode [3] = '{8'h80, 8'h82, 8'h84};
    logic [7:0] rcode [3] = '{8'h90, 8'h92, 8'h94};
    logic [7:0] bad [6] = '{8'h00, 8'h81, 8'h86, 8'h88, 8'h98, 8'hff};
    int n_errors = 0;
    int n_tests = 0;
    int n_xfer = 0;

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    srab_bridge #(.BAUD_DIV(14'h0010)) srab_bridge_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .uart_rx(uart_rx), .uart_tx_q(uart_tx_q),
        .spi_q(spi_q), .spi_miso(spi_miso), .busy_q(busy_q), .overrun_q(overrun_q));
    srab_conv_model srab_conv_model_inst (
        .cs_n(spi_q.cs_n), .sclk(spi_q.sclk), .mosi(spi_q.mosi), .miso(spi_miso),
        .result_val(result_val), .last_cmd(last_cmd));

    task automatic check(string what, logic [23:0] exp, logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reads give back the last word written, or the converter's own result
    function automatic logic [23:0] exp_read(logic [7:0] code);
        return (code == 8'h96) ? result_val : exp_reg[code[2:1]];
    endfunction

    always @(spi_q.cs_n) begin
        if (rst_n === 1'b1) check("sclk at select edge", 24'h0, {23'h0, spi_q.sclk});
        if (spi_q.cs_n === 1'b0) n_xfer++;
    end

    task automatic tx_byte(logic [7:0] b);
        for (int i = -1; i < 9; i++) begin
            @(negedge ref_clk);
            uart_rx = (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
            repeat (BIT - 1) @(negedge ref_clk);
        end
    endtask

    task automatic rx_byte(output logic [7:0] b);
        int t = 0;
        while (uart_tx_q !== 1'b0 && t < 4000) begin
            @(negedge ref_clk);
            t++;
        end
        check("reply start late", 24'h0, {23'h0, t >= 4000});
        repeat (BIT / 2) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge ref_clk);
            b[i] = uart_tx_q;
        end
        repeat (BIT) @(negedge ref_clk);
        check("stop bit", 24'h1, {23'h0, uart_tx_q});
    endtask

    task automatic rd_reg(logic [7:0] code, logic [23:0] exp);
        logic [7:0] b0, b1, b2;
        tx_byte(code);
        rx_byte(b0);
        rx_byte(b1);
        rx_byte(b2);
        check("read value", exp, {b2, b1, b0});
        check("command word", {16'h0, code}, {16'h0, last_cmd});
    endtask

    task automatic wr_reg(int k, logic [23:0] v);
        tx_byte(wcode[k]);
        for (int i = 0; i < 3; i++) tx_byte(v[8*i +: 8]);
        exp_reg[k] = v;
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        int x;
        int t;
        void'($urandom(33));
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check("idle lines", 24'h30, {18'h0, uart_tx_q, spi_q, busy_q, overrun_q});
        // Writes are streamed ahead of reads so they queue behind each other
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 3; k++) begin
                wr_reg(k, r == 0 ? 24'hffffff : r == 1 ? 24'h969290 : 24'($urandom()));
            end
            for (int k = 0; k < 3; k++) rd_reg(rcode[k], exp_read(rcode[k]));
        end
        for (int r = 0; r < 2; r++) begin
            @(negedge ref_clk);
            result_val = 24'($urandom());
            rd_reg(8'h96, exp_read(8'h96));
        end
        foreach (bad[i]) begin
            x = n_xfer;
            tx_byte(bad[i]);
            repeat (100) @(negedge ref_clk);
            check("transfers after unknown code", 24'(x), 24'(n_xfer));
        end
        rd_reg(8'h94, exp_read(8'h94));
        check("overrun before stream", 24'h0, {23'h0, overrun_q});
        // Reads arrive far faster than they are served, so the queue must spill
        repeat (24) tx_byte(8'h96);
        check("overrun after stream", 24'h1, {23'h0, overrun_q});
        // Busy dips for one cycle between queued commands, so wait for a quiet spell
        t = 0;
        x = 0;
        while (x < 40 && t < 40000) begin
            @(negedge ref_clk);
            x = (busy_q === 1'b0) ? x + 1 : 0;
            t++;
        end
        check("drain finished", 24'h0, {23'h0, t >= 40000});
        check("select idle after drain", 24'h1, {23'h0, spi_q.cs_n});
        check("overrun sticky", 24'h1, {23'h0, overrun_q});
        tally_and_finish();
    end
endmodule
